// [verilog/omsc_regs.svh]
// Register offsets, field positions, reset values and timing counts.
`ifndef OMSC_REGS_SVH
`define OMSC_REGS_SVH

// Register indices; the bus byte address is four times the index.
`define OMSC_IDX_MODE_STATUS 16'hfff1
`define OMSC_IDX_SYS_CONTROL 16'hfff2

// Mode status: bits 7:6 read one, bits 5:3 read zero.
`define OMSC_MS_FIXED 5'h18

// System control field positions and reset value.
`define OMSC_SC_RESET 8'h0b
`define OMSC_SC_STBY 7
`define OMSC_SC_STS_HI 6
`define OMSC_SC_STS_LO 4
`define OMSC_SC_UE 3
`define OMSC_SC_NMI_EDGE_SELECT 2
`define OMSC_SC_RSVD 1
`define OMSC_SC_RAM_ENABLE 0

// Oscillator settling waits in states (clock cycles).
`define OMSC_WAIT_0 8192
`define OMSC_WAIT_1 16384
`define OMSC_WAIT_2 32768
`define OMSC_WAIT_3 65536
`define OMSC_WAIT_4 131072
`define OMSC_WAIT_SHORT 4

// Start-up: pins are settled after two edges, captured at the third.
`define OMSC_BOOT_LAST 2'h2
`define OMSC_BOOT_DONE 2'h3

// Address pin enables for the two address space sizes.
`define OMSC_ADDR_1M 24'h0fffff
`define OMSC_ADDR_16M 24'hffffff

`endif

// [verilog/omsc_pkg.sv]
// Types shared by the mode and system control block.
package omsc_pkg;

	typedef enum logic [2:0] {
		OMSC_MODE_NONE = 3'b000,
		OMSC_MODE_1    = 3'b001,
		OMSC_MODE_2    = 3'b010,
		OMSC_MODE_3    = 3'b011,
		OMSC_MODE_4    = 3'b100
	} omsc_mode_e;

	typedef enum logic [1:0] {
		OMSC_RUN     = 2'b00,
		OMSC_SLEEP   = 2'b01,
		OMSC_STANDBY = 2'b10,
		OMSC_SETTLE  = 2'b11
	} omsc_pwr_e;

	typedef logic [17:0] omsc_cnt_t;

	typedef struct packed {
		omsc_pwr_e   pwr;
		logic [7:0]  ctl;
		logic [2:0]  seen;
		logic [7:0]  rdata;
		logic        slverr;
		logic [1:0]  boot;
		omsc_mode_e  mode;
		logic        bus16;
		logic        nmi_prev;
		logic        nmi_req;
		logic [23:0] addr_oe;
	} omsc_top_s;

	typedef struct packed {
		omsc_cnt_t cnt;
		logic      busy;
	} omsc_wait_s;

	typedef struct packed {
		logic [3:0] meta;
		logic [3:0] sync;
	} omsc_sync_s;

endpackage : omsc_pkg

// [verilog/omsc_sync.sv]
// Two-stage synchroniser for the mode-select pins and the NMI pin.
`timescale 1ns/1ps
module omsc_sync (
	input  wire  logic       clk,
	input  wire  logic       rst_n,
	input  wire  logic [3:0] async_in,
	output logic       [3:0] sync_out
);
	import omsc_pkg::*;

	omsc_sync_s q, d;

	// The first stage feeds only the second stage.
	always_comb
	begin
		d      = q;
		d.meta = async_in;
		d.sync = q.meta;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign sync_out = q.sync;

endmodule : omsc_sync

// [verilog/omsc_wait.sv]
// Down-counter that holds the oscillator settling wait.
`timescale 1ns/1ps
module omsc_wait (
	input  wire  logic      clk,
	input  wire  logic      rst_n,
	input  wire  logic      load,
	input  omsc_pkg::omsc_cnt_t len,
	output logic            busy,
	output logic            done
);
	import omsc_pkg::*;

	omsc_wait_s q, d;

	// A load starts a wait of exactly len cycles of busy.
	always_comb
	begin
		d = q;
		if (load)
		begin
			d.cnt  = len - 18'h1;
			d.busy = 1'b1;
		end
		else if (q.busy)
		begin
			d.cnt  = q.cnt - 18'h1;
			d.busy = (q.cnt != 18'h0);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign busy = q.busy;
	assign done = q.busy && (q.cnt == 18'h0);

	a_wait_load: assert property (@(posedge clk) disable iff (!rst_n)
		load |=> busy && q.cnt == $past(len) - 18'h1)
		else $error("Settling wait did not load its length.");

endmodule : omsc_wait

// [verilog/omsc_top.sv]
// Operating mode decode and system control registers on APB.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "omsc_regs.svh"
module omsc_top #(
	parameter int unsigned WAIT_0 = `OMSC_WAIT_0,
	parameter int unsigned WAIT_1 = `OMSC_WAIT_1,
	parameter int unsigned WAIT_2 = `OMSC_WAIT_2,
	parameter int unsigned WAIT_3 = `OMSC_WAIT_3,
	parameter int unsigned WAIT_4 = `OMSC_WAIT_4
) (
	input  wire  logic        SYS_CLK,
	input  wire  logic        RST_N,
	input  wire  logic        PSEL,
	input  wire  logic        PENABLE,
	input  wire  logic        PWRITE,
	input  wire  logic [17:0] PADDR,
	input  wire  logic [31:0] PWDATA,
	output logic        [31:0] PRDATA,
	output logic              PREADY,
	output logic              PSLVERR,
	input  wire  logic        MODE_SELECT_PIN_2,
	input  wire  logic        MODE_SELECT_PIN_1,
	input  wire  logic        MODE_SELECT_PIN_0,
	input  wire  logic        NMI_PIN,
	input  wire  logic        SLEEP_REQ,
	input  wire  logic        EXT_WAKE,
	input  wire  logic [7:0]  AREA_BUS_WIDTH,
	output omsc_pkg::omsc_mode_e OP_MODE,
	output logic        [23:0] ADDR_OE,
	output logic              BUS_16BIT,
	output logic              PORT4_IS_DATA,
	output logic              PORT5_IS_ADDR,
	output logic              RAM_ENABLE,
	output logic              UI_IS_MASK,
	output logic              NMI_REQ,
	output logic              SLEEP_ACTIVE,
	output logic              STANDBY_ACTIVE,
	output logic              SETTLE_ACTIVE
);
	import omsc_pkg::*;

	// State after reset: system control at its documented value.
	localparam omsc_top_s TOP_RESET = '{
		pwr:      OMSC_RUN,
		ctl:      `OMSC_SC_RESET,
		seen:     3'h0,
		rdata:    8'h00,
		slverr:   1'b0,
		boot:     2'h0,
		mode:     OMSC_MODE_NONE,
		bus16:    1'b0,
		nmi_prev: 1'b0,
		nmi_req:  1'b0,
		addr_oe:  24'h000000
	};

	omsc_top_s  q, d;
	logic [3:0] sync_s;
	logic [2:0] pins;
	logic       nmi_s;
	logic       setup;
	logic       wr;
	logic       rd;
	logic       hit_ms;
	logic       hit_sc;
	logic       wait_load;
	logic       wait_busy;
	logic       wait_done;
	omsc_cnt_t  wait_len;

	// True when the byte address matches a register index.
	function automatic logic omsc_hit(input logic [17:0] a, input logic [15:0] idx);
		return a == {idx, 2'b00};
	endfunction : omsc_hit

	// Settling wait length for a select code.
	function automatic omsc_cnt_t omsc_wait_len(input logic [2:0] sel);
		case (sel)
			3'b000: return omsc_cnt_t'(WAIT_0);
			3'b001: return omsc_cnt_t'(WAIT_1);
			3'b010: return omsc_cnt_t'(WAIT_2);
			3'b011: return omsc_cnt_t'(WAIT_3);
			3'b100,
			3'b101: return omsc_cnt_t'(WAIT_4);
			default: return omsc_cnt_t'(`OMSC_WAIT_SHORT);
		endcase
	endfunction : omsc_wait_len

	// Pins arrive from the board and pass two flip-flops first.
	omsc_sync u_sync (
		.clk      (SYS_CLK),
		.rst_n    (RST_N),
		.async_in ({NMI_PIN, MODE_SELECT_PIN_2, MODE_SELECT_PIN_1, MODE_SELECT_PIN_0}),
		.sync_out (sync_s)
	);

	assign pins  = sync_s[2:0];
	assign nmi_s = sync_s[3];

	// The wait counter runs the settling time after standby.
	omsc_wait u_wait (
		.clk   (SYS_CLK),
		.rst_n (RST_N),
		.load  (wait_load),
		.len   (wait_len),
		.busy  (wait_busy),
		.done  (wait_done)
	);

	assign wait_len = omsc_wait_len(q.ctl[`OMSC_SC_STS_HI:`OMSC_SC_STS_LO]);

	// APB phases and register decode.
	assign setup  = PSEL && !PENABLE;
	assign wr     = PSEL && PENABLE && PWRITE;
	assign rd     = setup && !PWRITE;
	assign hit_ms = omsc_hit(PADDR, `OMSC_IDX_MODE_STATUS);
	assign hit_sc = omsc_hit(PADDR, `OMSC_IDX_SYS_CONTROL);

	// Next-state logic for the whole block.
	always_comb
	begin
		omsc_mode_e m;
		m         = OMSC_MODE_NONE;
		d         = q;
		wait_load = 1'b0;

		// Start-up: capture the strapped mode once the pins are settled.
		if (pins inside {3'b001, 3'b010, 3'b011, 3'b100})
			m = omsc_mode_e'(pins);
		if (q.boot != `OMSC_BOOT_DONE)
			d.boot = q.boot + 2'h1;
		if (q.boot == `OMSC_BOOT_LAST)
		begin
			d.mode    = m;
			d.bus16   = (m == OMSC_MODE_2) || (m == OMSC_MODE_4);
			d.addr_oe = (m == OMSC_MODE_3) || (m == OMSC_MODE_4) ? `OMSC_ADDR_16M : `OMSC_ADDR_1M;
		end
		else if (q.boot == `OMSC_BOOT_DONE)
			d.bus16 = |AREA_BUS_WIDTH;

		// NMI request on the selected edge of the settled pin; none until the
		// synchroniser and the edge register hold real pin levels after reset.
		d.nmi_prev = nmi_s;
		d.nmi_req  = 1'b0;
		if (q.boot == `OMSC_BOOT_DONE)
		begin
			if (q.ctl[`OMSC_SC_NMI_EDGE_SELECT])
				d.nmi_req = nmi_s && !q.nmi_prev;
			else
				d.nmi_req = !nmi_s && q.nmi_prev;
		end

		// Read data and error are prepared in the setup phase.
		if (setup)
		begin
			d.slverr = !(hit_ms || hit_sc);
			d.rdata  = 8'h00;
			if (hit_ms && !PWRITE)
			begin
				d.seen  = pins;
				d.rdata = {`OMSC_MS_FIXED, pins};
			end
			else if (hit_sc && !PWRITE)
				d.rdata = q.ctl;
		end

		// Writes land in the access phase; mode status takes none.
		if (wr && hit_sc)
			d.ctl = {PWDATA[7:2], 1'b1, PWDATA[0]};

		// Power state: sleep, standby and the settling wait.
		case (q.pwr)
			OMSC_RUN:
				if (SLEEP_REQ)
					d.pwr = q.ctl[`OMSC_SC_STBY] ? OMSC_STANDBY : OMSC_SLEEP;
			OMSC_SLEEP:
				if (EXT_WAKE || q.nmi_req)
					d.pwr = OMSC_RUN;
			OMSC_STANDBY:
				if (EXT_WAKE || q.nmi_req)
				begin
					d.pwr     = OMSC_SETTLE;
					wait_load = 1'b1;
				end
			OMSC_SETTLE:
				if (wait_done)
					d.pwr = OMSC_RUN;
			default:
				d.pwr = OMSC_RUN;
		endcase
	end

	// All state registers; RAM enable returns to one at reset.
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			q <= TOP_RESET;
		else
			q <= d;
	end

	// Bus answer: zero wait states, error on unmapped addresses.
	assign PREADY  = 1'b1;
	assign PRDATA  = {24'h000000, q.rdata};
	assign PSLVERR = PSEL && PENABLE && q.slverr;

	// Mode-dependent pin functions and control outputs.
	assign OP_MODE        = q.mode;
	assign ADDR_OE        = q.addr_oe;
	assign BUS_16BIT      = q.bus16;
	assign PORT4_IS_DATA  = q.bus16;
	assign PORT5_IS_ADDR  = q.addr_oe[23];
	assign RAM_ENABLE     = q.ctl[`OMSC_SC_RAM_ENABLE];
	assign UI_IS_MASK     = !q.ctl[`OMSC_SC_UE];
	assign NMI_REQ        = q.nmi_req;
	assign SLEEP_ACTIVE   = (q.pwr == OMSC_SLEEP);
	assign STANDBY_ACTIVE = (q.pwr == OMSC_STANDBY);
	assign SETTLE_ACTIVE  = (q.pwr == OMSC_SETTLE);

	// Checks on the register file, the mode logic, NMI requests and the power states.
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	a_ms_ones_read: assert property (
		rd && hit_ms |=> PRDATA[7:6] == 2'b11)
		else $error("Mode status high bits not one.");

	a_ms_zero_read: assert property (
		rd && hit_ms |=> PRDATA[5:3] == 3'b000)
		else $error("Mode status middle bits not zero.");

	a_ms_pin_latch: assert property (
		rd && hit_ms |=> PRDATA[2:0] == $past(pins) && q.seen == $past(pins))
		else $error("Mode status does not show latched pins.");

	a_sleep_kind: assert property (
		q.pwr == OMSC_RUN && SLEEP_REQ |=>
			(STANDBY_ACTIVE == $past(q.ctl[7])) && (SLEEP_ACTIVE != $past(q.ctl[7])))
		else $error("Sleep request entered the wrong power state.");

	a_stby_kept: assert property (
		!(wr && hit_sc) |=> q.ctl[7] == $past(q.ctl[7]))
		else $error("Standby enable changed without a write.");

	a_settle_short: assert property (
		$rose(SETTLE_ACTIVE) && $past(q.ctl[6:5]) == 2'b11 |->
			SETTLE_ACTIVE [*4] ##1 !SETTLE_ACTIVE)
		else $error("Short settling wait is not four states.");

	a_ue_write: assert property (
		wr && hit_sc |=> UI_IS_MASK == !$past(PWDATA[3]))
		else $error("User bit enable does not follow the write.");

	a_nmi_fall: assert property (
		!q.ctl[2] && !nmi_s && q.nmi_prev ##1 !q.ctl[2] |-> NMI_REQ)
		else $error("Falling NMI edge not requested.");

	a_sc_bit_one: assert property (
		rd && hit_sc |=> PRDATA[1] && q.ctl[1])
		else $error("Reserved control bit not read as one.");

	a_ram_standby: assert property (
		q.pwr == OMSC_RUN && d.pwr == OMSC_STANDBY |=> $stable(RAM_ENABLE))
		else $error("Standby entry changed RAM enable.");

	a_addr_width: assert property (
		q.boot == `OMSC_BOOT_DONE |->
			ADDR_OE == ((OP_MODE == OMSC_MODE_3 || OP_MODE == OMSC_MODE_4) ? 24'hffffff : 24'h0fffff))
		else $error("Address pin enables do not match the mode.");

	a_bus_follow: assert property (
		q.boot == `OMSC_BOOT_DONE |=> BUS_16BIT == |$past(AREA_BUS_WIDTH))
		else $error("Bus width does not follow area widths.");

	a_ro_write: assert property (
		wr && hit_ms |=> $stable(q.ctl))
		else $error("Mode status write changed control state.");

	a_ms_no_error: assert property (
		wr && hit_ms |-> !PSLVERR)
		else $error("Mode status write answered with an error.");

	a_stby_write: assert property (
		wr && hit_sc |=> q.ctl[`OMSC_SC_STBY] == $past(PWDATA[7]))
		else $error("Standby enable does not follow the write.");

	a_ram_write: assert property (
		wr && hit_sc |=> RAM_ENABLE == $past(PWDATA[0]))
		else $error("RAM enable does not follow the write.");

	a_nmi_rise: assert property (
		q.boot == `OMSC_BOOT_DONE && q.ctl[`OMSC_SC_NMI_EDGE_SELECT] && nmi_s && !q.nmi_prev |=> NMI_REQ)
		else $error("Rising NMI edge not requested.");

	a_nmi_quiet: assert property (
		nmi_s == q.nmi_prev |=> !NMI_REQ)
		else $error("NMI request without a pin edge.");

	a_mode_capture: assert property (
		q.boot == `OMSC_BOOT_LAST && pins inside {3'b001, 3'b010, 3'b011, 3'b100} |=> OP_MODE == $past(pins))
		else $error("Strapped mode not captured.");

	a_bus_initial: assert property (
		q.boot == `OMSC_BOOT_LAST |=> BUS_16BIT == ($past(pins) == 3'b010 || $past(pins) == 3'b100))
		else $error("Initial bus width does not match the mode.");

	a_port4_data: assert property (
		q.boot == `OMSC_BOOT_DONE |=> PORT4_IS_DATA == |$past(AREA_BUS_WIDTH))
		else $error("Port 4 function does not follow the bus width.");

	a_port5_addr: assert property (
		q.boot == `OMSC_BOOT_DONE |-> PORT5_IS_ADDR == (OP_MODE == OMSC_MODE_3 || OP_MODE == OMSC_MODE_4))
		else $error("Port 5 function does not match the mode.");

	a_settle_load: assert property (
		$rose(SETTLE_ACTIVE) |-> wait_busy && !$past(wait_busy))
		else $error("Settling wait not started on wake.");

	a_settle_hold: assert property (
		q.pwr == OMSC_SETTLE && !wait_done |=> SETTLE_ACTIVE)
		else $error("Settling ended before its wait.");

	a_settle_end: assert property (
		q.pwr == OMSC_SETTLE && wait_done |=> q.pwr == OMSC_RUN)
		else $error("Run not resumed after the settling wait.");

endmodule : omsc_top

// [test/omsc_strap_model.sv]
// Board strapping model that drives the three mode-select pins.
`timescale 1ns/1ps
module omsc_strap_model (
	input  wire logic       clk,
	input  wire logic       load,
	input  wire logic [2:0] code,
	output logic      [2:0] pins
);
	// The straps only ever carry a valid mode and change only when loaded in reset.
	initial pins = 3'h1;
	always @(posedge clk)
	begin
		if (load && code >= 3'h1 && code <= 3'h4)
			pins <= code;
	end
endmodule : omsc_strap_model

// [test/omsc_top_tb_top.sv]
// Self-checking bench for the mode decode and system control block.
`timescale 1ns/1ps
`include "omsc_regs.svh"
module omsc_top_tb_top;
	import omsc_pkg::*;
	localparam logic [17:0] A_MS = 18'(4 * `OMSC_IDX_MODE_STATUS);
	localparam logic [17:0] A_SC = 18'(4 * `OMSC_IDX_SYS_CONTROL);
	logic SYS_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [17:0] PADDR = 0;
	logic [31:0] PWDATA = 0, PRDATA, rd;
	logic PREADY, PSLVERR, NMI_PIN = 1, SLEEP_REQ = 0, EXT_WAKE = 0, er, ld = 0;
	logic [7:0] AREA_BUS_WIDTH = 0, v;
	logic [2:0] code = 1, pins;
	omsc_mode_e OP_MODE;
	logic [23:0] ADDR_OE;
	logic BUS_16BIT, PORT4_IS_DATA, PORT5_IS_ADDR, RAM_ENABLE, UI_IS_MASK;
	logic NMI_REQ, SLEEP_ACTIVE, STANDBY_ACTIVE, SETTLE_ACTIVE;
	int seed = 3334, bad_count = 0, check_count = 0, cyc = 0, m, i;
	// A 50 MHz clock.
	always #10 SYS_CLK = ~SYS_CLK;
	omsc_strap_model strap_u (.clk(SYS_CLK), .load(ld), .code(code), .pins(pins));
	omsc_top #(.WAIT_0(8), .WAIT_1(9), .WAIT_2(10), .WAIT_3(11), .WAIT_4(12)) dut_u (
		.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.MODE_SELECT_PIN_2(pins[2]), .MODE_SELECT_PIN_1(pins[1]), .MODE_SELECT_PIN_0(pins[0]),
		.NMI_PIN(NMI_PIN), .SLEEP_REQ(SLEEP_REQ), .EXT_WAKE(EXT_WAKE),
		.AREA_BUS_WIDTH(AREA_BUS_WIDTH), .OP_MODE(OP_MODE), .ADDR_OE(ADDR_OE),
		.BUS_16BIT(BUS_16BIT), .PORT4_IS_DATA(PORT4_IS_DATA), .PORT5_IS_ADDR(PORT5_IS_ADDR),
		.RAM_ENABLE(RAM_ENABLE), .UI_IS_MASK(UI_IS_MASK), .NMI_REQ(NMI_REQ),
		.SLEEP_ACTIVE(SLEEP_ACTIVE), .STANDBY_ACTIVE(STANDBY_ACTIVE), .SETTLE_ACTIVE(SETTLE_ACTIVE));

	// Settling length expected for each select code with the shortened parameters.
	function automatic int exp_wait(input int c);
		case (c)
			0: return 8;
			1: return 9;
			2: return 10;
			3: return 11;
			4, 5: return 12;
			default: return 4;
		endcase
	endfunction : exp_wait

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	// Compares a seen value with the expected one.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One APB transfer: setup, then access held until pready is sampled high.
	task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		PSEL <= 1;
		PENABLE <= 0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1;
		do
		begin
			@(posedge SYS_CLK);
		end
		while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
	endtask : apb

	// Reads a register and checks its data and a clean response.
	task automatic rchk(input string nm, input logic [17:0] a, input logic [7:0] e);
		apb(0, a, 0);
		chk(nm, rd, {24'h0, e});
		chk("pslverr", {31'h0, er}, 0);
	endtask : rchk

	// Drives the sleep request (standby when v[7] is set, sleep otherwise), the wake pulse, and counts the settling cycles.
	task automatic standby_wake;
		@(posedge SYS_CLK);
		SLEEP_REQ <= 1;
		@(posedge SYS_CLK);
		SLEEP_REQ <= 0;
		EXT_WAKE <= 1;
		#1;
		chk("standby", {31'h0, STANDBY_ACTIVE}, v[7]);
		chk("sleep", {31'h0, SLEEP_ACTIVE}, !v[7]);
		@(posedge SYS_CLK);
		EXT_WAKE <= 0;
		m = 0;
		for (i = 0; i < 40; i++)
		begin
			#1;
			m += (SETTLE_ACTIVE !== 1'b0);
			@(posedge SYS_CLK);
		end
	endtask : standby_wake

	// Cuts a hung run short.
	always @(posedge SYS_CLK)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			bad_count++;
			summarize();
		end
	end

	// Main sequence: modes, registers, bus width, NMI edges, standby waits.
	initial
	begin
		for (int md = 1; md <= 4; md++)
		begin
			RST_N <= 0;
			ld <= 1;
			code <= md[2:0];
			repeat (8) @(posedge SYS_CLK);
			ld <= 0;
			RST_N <= 1;
			repeat (3) @(posedge SYS_CLK);
			#1;
			chk("bus16_init", {31'h0, BUS_16BIT}, md == 2 || md == 4);
			@(posedge SYS_CLK);
			#1;
			chk("op_mode", {29'h0, OP_MODE}, md);
			chk("addr_oe", {8'h0, ADDR_OE}, md > 2 ? 24'hffffff : 24'h0fffff);
			chk("port5", {31'h0, PORT5_IS_ADDR}, md > 2);
			chk("ram_en", {31'h0, RAM_ENABLE}, 1);
			chk("ui_mask", {31'h0, UI_IS_MASK}, 0);
			rchk("mode_status", A_MS, 8'hc0 | 8'(md));
			rchk("sys_ctl", A_SC, `OMSC_SC_RESET);
			apb(1, A_MS, $random(seed));
			rchk("ms_write", A_MS, 8'hc0 | 8'(md));
		end
		apb(0, A_SC + 18'h4, 0);
		chk("unmapped", {31'h0, er}, 1);
		for (int k = 0; k < 6; k++)
		begin
			v = 8'($random(seed)) & 8'h7f;
			apb(1, A_SC, {24'h0, v});
			rchk("sc_rw", A_SC, v | 8'h02);
			chk("ram_en", {31'h0, RAM_ENABLE}, v[0]);
			chk("ui_mask", {31'h0, UI_IS_MASK}, !v[3]);
		end
		for (int k = 0; k < 8; k++)
		begin
			@(posedge SYS_CLK);
			AREA_BUS_WIDTH <= k == 0 ? 8'h00 : k == 1 ? 8'h80 : 8'($random(seed));
			repeat (4) @(posedge SYS_CLK);
			#1;
			chk("bus16", {31'h0, BUS_16BIT}, |AREA_BUS_WIDTH);
			chk("port4", {31'h0, PORT4_IS_DATA}, |AREA_BUS_WIDTH);
		end
		for (int e = 0; e < 2; e++)
		begin
			apb(1, A_SC, {29'h1, e[0], 2'h3});
			for (int lv = 0; lv < 2; lv++)
			begin
				@(posedge SYS_CLK);
				NMI_PIN <= lv[0];
				m = 0;
				for (i = 0; i < 8; i++)
				begin
					@(posedge SYS_CLK);
					#1;
					m += (NMI_REQ !== 1'b0);
				end
				chk("nmi_req", m, e == lv);
			end
		end
		for (int c = 0; c < 8; c++)
		begin
			// Every settling code is tried; the shortened waits stand for a code long enough to settle.
			v = {1'b1, c[2:0], 3'h5, 1'($random(seed))};
			apb(1, A_SC, {24'h0, v});
			standby_wake();
			chk("settle_len", m, exp_wait(c));
			rchk("stby_kept", A_SC, v | 8'h02);
			chk("ram_kept", {31'h0, RAM_ENABLE}, v[0]);
		end
		v = 8'h0b;
		apb(1, A_SC, {24'h0, v});
		standby_wake();
		chk("no_settle", m, 0);
		chk("sleep_exit", {31'h0, SLEEP_ACTIVE}, 0);
		summarize();
	end
endmodule : omsc_top_tb_top
